// File: rtl/ccu_pkg.sv
// ---------------------------------------------------------------
// Register map and field layout
// ---------------------------------------------------------------
package ccu_pkg;
    localparam logic [3:0] ADR_T3_LO = 4'h0;
    localparam logic [3:0] ADR_T3_HI = 4'h1;
    localparam logic [3:0] ADR_T3_CTL = 4'h2;
    localparam logic [3:0] ADR_UNIT_CTL = 4'h3;
    localparam logic [3:0] ADR_VAL_LO = 4'h4;
    localparam logic [3:0] ADR_VAL_HI = 4'h5;
    localparam logic [3:0] ADR_FLAGS = 4'h6;
    localparam logic [3:0] ADR_CAN_IO = 4'h7;
    localparam int T3C_RD16 = 7;
    localparam int T3C_TBS_HI = 6;
    localparam int T3C_PS_HI = 5;
    localparam int T3C_PS_LO = 4;
    localparam int T3C_TBS_LO = 3;
    localparam int T3C_CS = 1;
    localparam int T3C_ON = 0;
    localparam int UC_DUTY_HI = 5;
    localparam int UC_DUTY_LO = 4;
    localparam int UC_MODE_HI = 3;
    localparam int FLG_CAP = 0;
    localparam int FLG_OVF = 1;
    localparam int CANIO_CAP = 4;
    localparam logic [7:0] T3_CTL_RST = 8'h00;
    localparam logic [7:0] UNIT_CTL_RST = 8'h00;
    localparam logic [7:0] UNIT_CTL_MASK = 8'h3F;
    localparam logic [15:0] T3_CNT_RST = 16'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [3:0] M_OFF = 4'h0;
    localparam logic [3:0] M_CMP_TGL = 4'h2;
    localparam logic [3:0] M_CAP_CAN = 4'h3;
    localparam logic [3:0] M_CAP_FALL = 4'h4;
    localparam logic [3:0] M_CAP_RISE = 4'h5;
    localparam logic [3:0] M_CAP_R4 = 4'h6;
    localparam logic [3:0] M_CAP_R16 = 4'h7;
    localparam logic [3:0] M_CMP_HI = 4'h8;
    localparam logic [3:0] M_CMP_LO = 4'h9;
    localparam logic [3:0] M_CMP_SW = 4'hA;
    localparam logic [3:0] M_CMP_SET = 4'hB;
    localparam logic [1:0] PWM_TAG = 2'h3;
    localparam logic [3:0] PS4_MASK = 4'h3;
    localparam logic [3:0] PS16_MASK = 4'hF;
endpackage : ccu_pkg

// File: rtl/ccu_top.sv
`timescale 1ns/1ps
module ccu_top (
    // Clock and reset
    input logic clk,
    input logic nrst,
    // Register port
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    // Capture pin and its direction latch
    input logic capture_pin_in,
    output logic capture_pin_out,
    output logic capture_pin_oe_n,
    input logic port_direction,
    // Primary and secondary timers
    input logic [15:0] primary_timer_value,
    output logic primary_timer_reset,
    input logic secondary_ext_clk,
    output logic [15:0] secondary_timer_value,
    output logic secondary_overflow_flag,
    output logic enh_time_base_secondary,
    // Third timer, shared PWM time base
    input logic [7:0] third_timer_count,
    input logic [1:0] third_timer_sub,
    input logic third_timer_period,
    // CAN controller, converter, flag
    input logic can_msg_received,
    input logic adc_enabled,
    output logic adc_start,
    output logic capture_irq_flag
);
    logic [7:0] t3_ctl_r;
    logic [7:0] ucon_r;
    logic [7:0] val_lo_r;
    logic [7:0] val_hi_r;
    logic [7:0] t3_hbuf_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_nxt;
    logic [15:0] t3_cnt_r;
    logic [2:0] t3_ps_r;
    logic [2:0] ps_lim;
    logic [9:0] duty_r;
    logic [9:0] duty_nxt;
    logic [3:0] psc_r;
    logic [3:0] mode;
    logic [3:0] mode_d_r;
    logic [1:0] pin_sync_r;
    logic [1:0] ext_sync_r;
    logic [15:0] tb;
    logic ext_d_r, src_d_r, can_d_r, match_d_r;
    logic out_r, oe_n_r, flag_r, ovf_r, can_en_r;
    logic prim_rst_r, adc_r;
    logic is_cap, is_cmp, is_pwm, use_sec, rd16;
    logic wr_lo, wr_hi, t3_wr, t3_src, t3_tick;
    logic src, rise, fall, can_rise, cap_ev;
    logic match, cmp_hit, set_fire, sec_reset;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign mode = ucon_r[ccu_pkg::UC_MODE_HI:0];
    assign is_pwm = mode[3:2] == ccu_pkg::PWM_TAG;
    assign is_cap = (mode >= ccu_pkg::M_CAP_CAN)
        && (mode <= ccu_pkg::M_CAP_R16);
    assign is_cmp = (mode == ccu_pkg::M_CMP_TGL)
        || ((mode >= ccu_pkg::M_CMP_HI) && !is_pwm);
    // Only the high select bit picks the time base; both bits drive enh_time_base_secondary
    assign use_sec = t3_ctl_r[ccu_pkg::T3C_TBS_HI];
    assign enh_time_base_secondary = t3_ctl_r[ccu_pkg::T3C_TBS_HI]
        | t3_ctl_r[ccu_pkg::T3C_TBS_LO];
    assign tb = use_sec ? t3_cnt_r : primary_timer_value;
    assign rd16 = t3_ctl_r[ccu_pkg::T3C_RD16];
    assign wr_lo = reg_wr && (reg_addr == ccu_pkg::ADR_T3_LO);
    assign wr_hi = reg_wr && (reg_addr == ccu_pkg::ADR_T3_HI);
    assign t3_wr = wr_lo || (wr_hi && !rd16);

    // ---------------------------------------------------------------
    // Synchronisers
    // ---------------------------------------------------------------
    // Second stage only feeds logic; first stage is never looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync_r <= 2'h0;
            ext_sync_r <= 2'h0;
            ext_d_r <= 1'h0;
            src_d_r <= 1'h0;
            can_d_r <= 1'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], capture_pin_in};
            ext_sync_r <= {ext_sync_r[0], secondary_ext_clk};
            ext_d_r <= ext_sync_r[1];
            src_d_r <= src;
            can_d_r <= can_msg_received;
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t3_ctl_r <= ccu_pkg::T3_CTL_RST;
            ucon_r <= ccu_pkg::UNIT_CTL_RST;
            can_en_r <= 1'h0;
        end else if (reg_wr) begin
            if (reg_addr == ccu_pkg::ADR_T3_CTL) begin
                t3_ctl_r <= reg_wdata;
            end else if (reg_addr == ccu_pkg::ADR_UNIT_CTL) begin
                ucon_r <= reg_wdata & ccu_pkg::UNIT_CTL_MASK;
            end else if (reg_addr == ccu_pkg::ADR_CAN_IO) begin
                can_en_r <= reg_wdata[ccu_pkg::CANIO_CAP];
            end
        end
    end

    // Capture beats a same-cycle software write to the pair
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {val_hi_r, val_lo_r} <= ccu_pkg::VAL_RST;
        end else if (cap_ev) begin
            {val_hi_r, val_lo_r} <= tb;
        end else if (reg_wr && (reg_addr == ccu_pkg::ADR_VAL_LO)) begin
            val_lo_r <= reg_wdata;
        end else if (reg_wr && (reg_addr == ccu_pkg::ADR_VAL_HI)) begin
            val_hi_r <= reg_wdata;
        end
    end

    // ---------------------------------------------------------------
    // Secondary timer
    // ---------------------------------------------------------------
    assign ps_lim = 3'((4'h1 << t3_ctl_r[ccu_pkg::T3C_PS_HI:
        ccu_pkg::T3C_PS_LO]) - 4'h1);
    assign t3_src = t3_ctl_r[ccu_pkg::T3C_CS]
        ? (ext_sync_r[1] && !ext_d_r) : 1'h1;
    assign t3_tick = t3_ctl_r[ccu_pkg::T3C_ON] && t3_src
        && (t3_ps_r == ps_lim);
    assign sec_reset = set_fire && use_sec;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t3_ps_r <= 3'h0;
        end else if (t3_wr || (t3_ctl_r[ccu_pkg::T3C_ON] && t3_tick)) begin
            t3_ps_r <= 3'h0;
        end else if (t3_ctl_r[ccu_pkg::T3C_ON] && t3_src) begin
            t3_ps_r <= t3_ps_r + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t3_cnt_r <= ccu_pkg::T3_CNT_RST;
        end else if (wr_lo) begin
            t3_cnt_r[7:0] <= reg_wdata;
            if (rd16) begin
                t3_cnt_r[15:8] <= t3_hbuf_r;
            end
        end else if (wr_hi && !rd16) begin
            t3_cnt_r[15:8] <= reg_wdata;
        end else if (sec_reset) begin
            t3_cnt_r <= ccu_pkg::T3_CNT_RST;
        end else if (t3_tick) begin
            t3_cnt_r <= t3_cnt_r + 16'h1;
        end
    end

    // High byte buffer gives a coherent 16-bit read or write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t3_hbuf_r <= 8'h00;
        end else if (reg_rd && (reg_addr == ccu_pkg::ADR_T3_LO)) begin
            t3_hbuf_r <= t3_cnt_r[15:8];
        end else if (wr_hi && rd16) begin
            t3_hbuf_r <= reg_wdata;
        end
    end

    // Overflow only from counting; a trigger reset never sets it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_r <= 1'h0;
        end else if (t3_tick && !t3_wr && !sec_reset
            && (t3_cnt_r == 16'hFFFF)) begin
            ovf_r <= 1'h1;
        end else if (reg_wr && (reg_addr == ccu_pkg::ADR_FLAGS)
            && reg_wdata[ccu_pkg::FLG_OVF]) begin
            ovf_r <= 1'h0;
        end
    end

    // ---------------------------------------------------------------
    // Capture
    // ---------------------------------------------------------------
    assign src = can_en_r ? can_msg_received : pin_sync_r[1];
    assign rise = src && !src_d_r;
    assign fall = !src && src_d_r;
    assign can_rise = can_msg_received && !can_d_r;

    // Prescaler holds across prescale changes; only leaving capture clears
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            psc_r <= 4'h0;
        end else if (!is_cap) begin
            psc_r <= 4'h0;
        end else if (rise) begin
            psc_r <= psc_r + 4'h1;
        end
    end

    always_comb begin
        cap_ev = 1'h0;
        case (mode)
            ccu_pkg::M_CAP_CAN: cap_ev = can_rise;
            ccu_pkg::M_CAP_FALL: cap_ev = fall;
            ccu_pkg::M_CAP_RISE: cap_ev = rise;
            ccu_pkg::M_CAP_R4: cap_ev = rise
                && ((psc_r & ccu_pkg::PS4_MASK) == ccu_pkg::PS4_MASK);
            ccu_pkg::M_CAP_R16: cap_ev = rise
                && (psc_r == ccu_pkg::PS16_MASK);
            default: cap_ev = 1'h0;
        endcase
    end

    // ---------------------------------------------------------------
    // Compare
    // ---------------------------------------------------------------
    // Edge of the match, so a prescaled timer resting on the value
    // fires once, not on every clock
    assign match = {val_hi_r, val_lo_r} == tb;
    assign cmp_hit = is_cmp && match && !match_d_r;
    assign set_fire = cmp_hit && (mode == ccu_pkg::M_CMP_SET);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            match_d_r <= 1'h0;
            mode_d_r <= ccu_pkg::M_OFF;
            prim_rst_r <= 1'h0;
            adc_r <= 1'h0;
        end else begin
            match_d_r <= match;
            mode_d_r <= mode;
            prim_rst_r <= set_fire && !use_sec;
            adc_r <= set_fire && adc_enabled;
        end
    end

    // ---------------------------------------------------------------
    // Pin output latch, compare and PWM
    // ---------------------------------------------------------------
    assign duty_nxt = {val_lo_r,
        ucon_r[ccu_pkg::UC_DUTY_HI:ccu_pkg::UC_DUTY_LO]};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            duty_r <= 10'h000;
        end else if (is_pwm && third_timer_period) begin
            duty_r <= duty_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_r <= 1'h0;
        end else if (mode == ccu_pkg::M_OFF) begin
            out_r <= 1'h0;
        end else if (is_pwm) begin
            if (third_timer_period) begin
                out_r <= duty_nxt != 10'h000;
            end else if ({third_timer_count, third_timer_sub} == duty_r) begin
                out_r <= 1'h0;
            end
        end else if ((mode != mode_d_r) && (mode == ccu_pkg::M_CMP_HI)) begin
            out_r <= 1'h0;
        end else if ((mode != mode_d_r) && (mode == ccu_pkg::M_CMP_LO)) begin
            out_r <= 1'h1;
        end else if (cmp_hit && (mode == ccu_pkg::M_CMP_TGL)) begin
            out_r <= !out_r;
        end else if (cmp_hit && (mode == ccu_pkg::M_CMP_HI)) begin
            out_r <= 1'h1;
        end else if (cmp_hit && (mode == ccu_pkg::M_CMP_LO)) begin
            out_r <= 1'h0;
        end
    end

    // Any compare match or capture raises the flag; set beats clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'h0;
            oe_n_r <= 1'h1;
        end else begin
            oe_n_r <= port_direction;
            if (cap_ev || cmp_hit) begin
                flag_r <= 1'h1;
            end else if (reg_wr && (reg_addr == ccu_pkg::ADR_FLAGS)
                && reg_wdata[ccu_pkg::FLG_CAP]) begin
                flag_r <= 1'h0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        rd_nxt = 8'h00;
        if (reg_addr == ccu_pkg::ADR_T3_LO) begin
            rd_nxt = t3_cnt_r[7:0];
        end else if (reg_addr == ccu_pkg::ADR_T3_HI) begin
            rd_nxt = rd16 ? t3_hbuf_r : t3_cnt_r[15:8];
        end else if (reg_addr == ccu_pkg::ADR_T3_CTL) begin
            rd_nxt = t3_ctl_r;
        end else if (reg_addr == ccu_pkg::ADR_UNIT_CTL) begin
            rd_nxt = ucon_r;
        end else if (reg_addr == ccu_pkg::ADR_VAL_LO) begin
            rd_nxt = val_lo_r;
        end else if (reg_addr == ccu_pkg::ADR_VAL_HI) begin
            rd_nxt = val_hi_r;
        end else if (reg_addr == ccu_pkg::ADR_FLAGS) begin
            rd_nxt[ccu_pkg::FLG_CAP] = flag_r;
            rd_nxt[ccu_pkg::FLG_OVF] = ovf_r;
        end else if (reg_addr == ccu_pkg::ADR_CAN_IO) begin
            rd_nxt[ccu_pkg::CANIO_CAP] = can_en_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_nxt : 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign capture_pin_out = out_r;
    assign capture_pin_oe_n = oe_n_r;
    assign secondary_timer_value = t3_cnt_r;
    assign secondary_overflow_flag = ovf_r;
    assign primary_timer_reset = prim_rst_r;
    assign adc_start = adc_r;
    assign capture_irq_flag = flag_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_trig_clr;
        (sec_reset && !t3_wr) |=> (t3_cnt_r == 16'h0000) && !$rose(ovf_r);
    endproperty
    a_trig_clr: assert property (p_trig_clr)
        else $error("trigger did not clear timer cleanly");

    property p_wr_wins;
        (sec_reset && wr_lo) |=> (t3_cnt_r[7:0] == $past(reg_wdata));
    endproperty
    a_wr_wins: assert property (p_wr_wins)
        else $error("trigger beat a timer write");

    property p_off;
        (mode == ccu_pkg::M_OFF) |=> !capture_pin_out && (psc_r == 4'h0);
    endproperty
    a_off: assert property (p_off)
        else $error("unit not reset while off");

    property p_toggle;
        (cmp_hit && (mode == ccu_pkg::M_CMP_TGL))
            |=> (out_r != $past(out_r)) && capture_irq_flag;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle match wrong");

    property p_init_hi;
        ((mode != mode_d_r) && (mode == ccu_pkg::M_CMP_LO)) |=> out_r;
    endproperty
    a_init_hi: assert property (p_init_hi)
        else $error("pin not initialised high");

    property p_sw_only;
        (cmp_hit && (mode == ccu_pkg::M_CMP_SW) && (mode == mode_d_r))
            |=> $stable(out_r) && capture_irq_flag;
    endproperty
    a_sw_only: assert property (p_sw_only)
        else $error("software compare touched pin");

    property p_adc;
        (set_fire && adc_enabled) |=> adc_start ##1 !adc_start;
    endproperty
    a_adc: assert property (p_adc)
        else $error("converter start not one pulse");

    property p_capture;
        cap_ev |=> ({val_hi_r, val_lo_r} == $past(tb)) && capture_irq_flag;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value or flag wrong");

    property p_strobe;
        rise |=> !rise;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("edge strobe longer than one cycle");
endmodule : ccu_top

// File: test/ccu_far_end.sv
`timescale 1ns/1ps
module ccu_far_end #(
    parameter logic [9:0] PWM_TOP = 10'h03F
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Primary timer, steered by the bench
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic run,
    input wire logic primary_timer_reset,
    output logic [15:0] primary_timer_value,
    // Third timer
    output logic [7:0] third_timer_count,
    output logic [1:0] third_timer_sub,
    output logic third_timer_period,
    // Capture pin wire
    input wire logic tb_pin,
    input wire logic capture_pin_out,
    input wire logic capture_pin_oe_n,
    output logic capture_pin_in
);
    // ---------------------------------------------------------------
    // Timers
    // ---------------------------------------------------------------
    logic [9:0] pwm_cnt_r;
    // Same clock as the unit: no asynchronous counting mode exists
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            primary_timer_value <= 16'h0000;
        end else if (load) begin
            primary_timer_value <= load_val;
        end else if (primary_timer_reset) begin
            primary_timer_value <= 16'h0000;
        end else if (run) begin
            primary_timer_value <= primary_timer_value + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwm_cnt_r <= 10'h000;
        end else begin
            pwm_cnt_r <= (pwm_cnt_r == PWM_TOP) ? 10'h000
                : pwm_cnt_r + 10'h001;
        end
    end
    assign third_timer_count = pwm_cnt_r[9:2];
    assign third_timer_sub = pwm_cnt_r[1:0];
    assign third_timer_period = (pwm_cnt_r == 10'h000);
    // ---------------------------------------------------------------
    // Pin
    // ---------------------------------------------------------------
    // The detector sees the wire, so a driven pin can capture itself
    assign capture_pin_in = capture_pin_oe_n ? tb_pin : capture_pin_out;
endmodule : ccu_far_end

// File: test/capture_compare_unit_tb.sv
`timescale 1ns/1ps
module capture_compare_unit_tb;
    // ---------------------------------------------------------------
    // Signals and cases
    // ---------------------------------------------------------------
    typedef struct {
        logic [3:0] mode;
        logic can;
        logic canen;
        int n;
        logic [15:0] ts;
        logic flag;
        logic pre;
        logic pin;
        logic [15:0] vp;
    } ccu_row_s;
    logic clk;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic port_direction = 1'b1;
    logic tb_pin = 1'b0;
    logic can_msg_received = 1'b0;
    logic adc_enabled = 1'b1;
    logic load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic run = 1'b0;
    logic ext_clk = 1'b0;
    logic [7:0] reg_rdata, third_timer_count, d;
    logic [15:0] primary_timer_value, secondary_timer_value, v, mx;
    logic capture_pin_in, capture_pin_out, capture_pin_oe_n;
    logic primary_timer_reset, secondary_overflow_flag, third_timer_period;
    logic enh_time_base_secondary, adc_start, capture_irq_flag;
    logic [1:0] third_timer_sub;
    int miscompares = 0;
    int checks = 0;
    int hc, na;
    // Capture rows hold the timer still; compare rows let it run
    ccu_row_s rows [16] = '{
        '{4'h4, 0, 0, 1, 16'h0A50, 1, 0, 0, 16'h0A50},
        '{4'h5, 0, 0, 1, 16'h0A51, 1, 0, 0, 16'h0A51},
        '{4'h6, 0, 0, 3, 16'h0A52, 0, 0, 0, 16'h1234},
        '{4'h6, 0, 0, 4, 16'h0A53, 1, 0, 0, 16'h0A53},
        '{4'h7, 0, 0, 15, 16'h0A54, 0, 0, 0, 16'h1234},
        '{4'h7, 0, 0, 16, 16'h0A55, 1, 0, 0, 16'h0A55},
        '{4'h3, 1, 0, 1, 16'h0A56, 1, 0, 0, 16'h0A56},
        '{4'h5, 1, 1, 1, 16'h0A57, 1, 0, 0, 16'h0A57},
        '{4'h5, 0, 1, 1, 16'h0A58, 0, 0, 0, 16'h1234},
        '{4'h1, 0, 0, 1, 16'h0A59, 0, 0, 0, 16'h1234},
        '{4'h2, 0, 0, 0, 16'h1231, 1, 0, 1, 16'h1234},
        '{4'h8, 0, 0, 0, 16'h1231, 1, 0, 1, 16'h1234},
        '{4'h9, 0, 0, 0, 16'h1231, 1, 1, 0, 16'h1234},
        '{4'hA, 0, 0, 0, 16'h1231, 1, 0, 0, 16'h1234},
        '{4'hB, 0, 0, 0, 16'h1231, 1, 0, 0, 16'h1234},
        '{4'h0, 0, 0, 0, 16'h1231, 0, 0, 0, 16'h1234}
    };
    ccu_top i_dut (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .capture_pin_in, .capture_pin_out, .capture_pin_oe_n, .port_direction,
        .primary_timer_value, .primary_timer_reset, .secondary_ext_clk(ext_clk),
        .secondary_timer_value, .secondary_overflow_flag,
        .enh_time_base_secondary, .third_timer_count, .third_timer_sub,
        .third_timer_period, .can_msg_received, .adc_enabled, .adc_start,
        .capture_irq_flag
    );
    ccu_far_end i_far (
        .clk, .nrst, .load, .load_val, .run, .primary_timer_reset,
        .primary_timer_value, .third_timer_count, .third_timer_sub,
        .third_timer_period, .tb_pin, .capture_pin_out, .capture_pin_oe_n,
        .capture_pin_in
    );
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        x = reg_rdata;
    endtask : rd
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic pulse(input logic can, input int n);
        repeat (n) begin
            @(posedge clk);
            if (can) can_msg_received <= 1'b1;
            else tb_pin <= 1'b1;
            repeat (3) @(posedge clk);
            can_msg_received <= 1'b0;
            tb_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : pulse
    task automatic ld(input logic [15:0] x);
        @(posedge clk);
        load <= 1'b1;
        load_val <= x;
        @(posedge clk);
        load <= 1'b0;
    endtask : ld
    // A mode change may leave a false capture behind: clear it
    task automatic settle_clr();
        repeat (6) @(posedge clk);
        wr(4'h6, 8'h01);
    endtask : settle_clr
    task automatic peek();
        repeat (6) @(posedge clk);
        rd(4'h6, d);
        rd(4'h4, v[7:0]);
        rd(4'h5, v[15:8]);
    endtask : peek
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            wr(4'h3, 8'h00);
            wr(4'h7, rows[i].canen ? 8'h10 : 8'h00);
            wr(4'h4, 8'h34);
            wr(4'h5, 8'h12);
            ld(rows[i].ts);
            wr(4'h3, {4'h0, rows[i].mode});
            settle_clr();
            @(negedge clk);
            chk("pin start", capture_pin_out, rows[i].pre);
            if (rows[i].n > 0) begin
                pulse(rows[i].can, rows[i].n);
            end else begin
                @(posedge clk);
                run <= 1'b1;
                repeat (8) @(posedge clk);
                run <= 1'b0;
            end
            peek();
            chk("flag", d[0], rows[i].flag);
            chk("irq", capture_irq_flag, rows[i].flag);
            chk("pin", capture_pin_out, rows[i].pin);
            chk("pair", v, rows[i].vp);
            chk("timer", primary_timer_value < 16'h0010,
                rows[i].mode == 4'hB);
        end
        @(posedge clk);
        port_direction <= 1'b0;
        wr(4'h3, 8'h09);
        wr(4'h3, 8'h04);
        settle_clr();
        @(posedge clk);
        port_direction <= 1'b1;
        peek();
        chk("own pin", d[0], 16'h0001);
        @(posedge clk);
        port_direction <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        chk("oe_n reset", capture_pin_oe_n, 16'h0001);
        chk("pin reset", capture_pin_out, 16'h0000);
        repeat (2) @(posedge clk);
        port_direction <= 1'b1;
        nrst <= 1'b1;
        wr(4'h8, 8'hFF);
        for (int a = 0; a < 9; a++) begin
            rd(a[3:0], d);
            chk("reset read", d, 16'h0000);
        end
        wr(4'h3, 8'hFF);
        rd(4'h3, d);
        chk("ctl bits", d, 16'h003F);
        @(posedge clk);
        port_direction <= 1'b0;
        repeat (3) @(negedge clk);
        chk("oe_n", capture_pin_oe_n, 16'h0000);
        @(posedge clk);
        port_direction <= 1'b1;
        wr(4'h3, 8'h05);
        settle_clr();
        ld(16'h0AA1);
        pulse(1'b0, 1);
        ld(16'h0BB2);
        pulse(1'b0, 1);
        peek();
        chk("overwrite", v, 16'h0BB2);
        wr(4'h3, 8'h00);
        wr(4'h3, 8'h06);
        settle_clr();
        pulse(1'b0, 2);
        wr(4'h3, 8'h07);
        settle_clr();
        pulse(1'b0, 13);
        peek();
        chk("kept count", d[0], 16'h0000);
        pulse(1'b0, 1);
        peek();
        chk("kept count", d[0], 16'h0001);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h04);
        for (int k = 0; k < 2; k++) begin
            wr(4'h3, k ? 8'h2F : 8'h2C);
            repeat (130) @(negedge clk);
            hc = 0;
            repeat (128) begin
                @(negedge clk);
                hc += capture_pin_out;
            end
            chk("pwm high", hc[15:0], 16'h0024);
        end
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h05);
        wr(4'h5, 8'h00);
        wr(4'h2, 8'h41);
        wr(4'h3, 8'h0B);
        wr(4'h6, 8'h03);
        mx = 16'h0000;
        na = 0;
        repeat (70) begin
            @(negedge clk);
            if (secondary_timer_value > mx) mx = secondary_timer_value;
            na += adc_start;
        end
        chk("period", mx > 16'h0004 && mx < 16'h0007, 16'h0001);
        chk("no ovf", secondary_overflow_flag, 16'h0000);
        chk("adc", na > 5, 16'h0001);
        chk("enh base", enh_time_base_secondary, 16'h0001);
        wr(4'h2, 8'h40);
        wr(4'h0, 8'h00);
        // Pair write makes the match; timer write lands on the trigger
        @(posedge clk);
        reg_addr <= 4'h4;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_addr <= 4'h0;
        reg_wdata <= 8'h77;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
        chk("write wins", secondary_timer_value, 16'h0077);
        wr(4'h1, 8'hFF);
        wr(4'h0, 8'hFF);
        wr(4'h2, 8'h41);
        repeat (4) @(negedge clk);
        chk("ovf", secondary_overflow_flag, 16'h0001);
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h02);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h03);
        repeat (3) begin
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (3) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        @(negedge clk);
        chk("ext count", secondary_timer_value, 16'h0003);
        wrap_up();
    end
endmodule : capture_compare_unit_tb
